// ===== shared/serial_flags_regs.svh
// Purpose: register offsets, field positions, reset values and sizes
// Assumes: byte addresses on a 32-bit Avalon-MM slave
// Notes:   included by the flag block and the verification side
`ifndef SERIAL_FLAGS_REGS_SVH
`define SERIAL_FLAGS_REGS_SVH

`define SF_OFF_STATUS     8'h00
`define SF_OFF_TXDATA     8'h04
`define SF_OFF_SERCTL     8'h08
`define SF_OFF_FIFOCTL    8'h0c
`define SF_OFF_COUNT      8'h10
`define SF_OFF_RXDATA     8'h14
`define SF_OFF_IRQ_STAT   8'h18
`define SF_OFF_IRQ_CLR    8'h1c
`define SF_OFF_IRQ_EN     8'h20

`define SF_BIT_DONE       6
`define SF_BIT_LOW        5
`define SF_BIT_BREAK      4
`define SF_BIT_FRAMING    3
`define SF_BIT_PARITY     2
`define SF_STATUS_RESET   32'h0000_0060

`define SF_BIT_TXEN       5
`define SF_BIT_SYNC       7
`define SF_SERCTL_RESET   8'h00
`define SF_TRIG_LSB       4
`define SF_FIFOCTL_RESET  8'h00
`define SF_COUNT_LSB      8

`define SF_IRQ_DONE       0
`define SF_IRQ_LOW        1
`define SF_IRQ_BREAK      2

`define SF_TX_DEPTH       16
`define SF_TRIG_0         5'h08
`define SF_TRIG_1         5'h04
`define SF_TRIG_2         5'h02
`define SF_TRIG_3         5'h01

`endif

// ===== shared/serial_flags_pkg.sv
// Purpose: types shared by the flag block and its environment
// Assumes: nothing beyond the register header
// Notes:   one received character with its error marks
package serial_flags_pkg;

  typedef struct packed {
    logic [7:0] data;
    logic       frame_err;
    logic       parity_err;
  } rx_char_s;

  typedef logic [2:0] irq_bits_t;

endpackage : serial_flags_pkg

// ===== hw/tx_byte_fifo.sv
// Purpose: transmit byte fifo with a registered head and count
// Assumes: push is only offered when not full, pop only when valid
// Notes:   head, valid and count all come from flip-flops
module tx_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH) + 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head,
  output logic                  head_valid,
  output logic      [CW-1:0]    count
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    wr_ptr;

  wire [AW-1:0]    rd_next    = AW'(rd_ptr + 1'b1);
  wire [CW-1:0]    next_count = CW'(count + CW'(push) - CW'(pop));
  wire [WIDTH-1:0] next_head  = pop ? ((count > CW'(1)) ? mem[rd_next] : push_data)
                                    : ((count == '0) ? push_data : head);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ptr     <= '0;
      wr_ptr     <= '0;
      count      <= '0;
      head       <= '0;
      head_valid <= 1'b0;
    end else begin
      if (push) wr_ptr <= AW'(wr_ptr + 1'b1);
      if (pop) rd_ptr <= rd_next;
      count      <= next_count;
      head       <= next_head;
      head_valid <= (next_count != '0);
    end
  end

endmodule : tx_byte_fifo

// ===== hw/serial_fifo_status_flags.sv
// Purpose: status flags of a fifo-buffered serial port, on Avalon-MM
// Assumes: shifter, receiver and receive fifo run on clk
// Notes:   every access takes two cycles; standby acts like reset on flags
`include "serial_flags_regs.svh"

module serial_fifo_status_flags
  import serial_flags_pkg::*;
#(
  parameter int DEPTH = `SF_TX_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        standby,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        dma_valid,
  input  wire logic [7:0]  dma_data,
  output logic             dma_ack,
  output logic      [7:0]  tx_head,
  output logic             tx_head_valid,
  input  wire logic        tx_take,
  input  wire logic        tx_char_done,
  input  wire logic        rx_char_valid,
  input  wire rx_char_s    rx_char,
  input  wire logic        rx_line,
  output logic             rx_load,
  output rx_char_s         rx_load_char,
  input  wire rx_char_s    rx_head,
  output logic             rx_pop,
  output logic             irq
);
  localparam int CW = $clog2(DEPTH) + 1;

  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0:    trig_level = `SF_TRIG_0;
      2'h1:    trig_level = `SF_TRIG_1;
      2'h2:    trig_level = `SF_TRIG_2;
      default: trig_level = `SF_TRIG_3;
    endcase
  endfunction : trig_level

  logic [CW-1:0] count;
  logic [CW-1:0] added;
  logic [7:0]    serial_control_reg;
  logic [7:0]    fifo_control_reg;
  logic          transmit_done_flag;
  logic          tx_fifo_low_flag;
  logic          line_break_flag;
  logic          framing_fault_flag;
  logic          parity_fault_flag;
  logic          arm_low;
  logic          arm_break;
  logic          prev_frame_err;
  logic          break_hold;
  logic          line_meta;
  logic          line_sync;
  irq_bits_t     irq_status;
  irq_bits_t     irq_enable;

  // bus decode
  wire acc_rd     = avs_read && !avs_waitrequest;
  wire acc_wr     = avs_write && !avs_waitrequest;
  wire lane0      = avs_byteenable[0];
  wire sel_status = (avs_address == `SF_OFF_STATUS);
  wire sel_txdata = (avs_address == `SF_OFF_TXDATA);
  wire sel_serctl = (avs_address == `SF_OFF_SERCTL);
  wire sel_fifoct = (avs_address == `SF_OFF_FIFOCTL);
  wire sel_count  = (avs_address == `SF_OFF_COUNT);
  wire sel_rxdata = (avs_address == `SF_OFF_RXDATA);
  wire sel_istat  = (avs_address == `SF_OFF_IRQ_STAT);
  wire sel_iclr   = (avs_address == `SF_OFF_IRQ_CLR);
  wire sel_ien    = (avs_address == `SF_OFF_IRQ_EN);

  wire tx_enable_ctl     = serial_control_reg[`SF_BIT_TXEN];
  wire sync_mode         = serial_control_reg[`SF_BIT_SYNC];
  wire tx_trigger_sel_hi = fifo_control_reg[`SF_TRIG_LSB+1];
  wire tx_trigger_sel_lo = fifo_control_reg[`SF_TRIG_LSB];
  wire [CW-1:0] trig     = CW'(trig_level({tx_trigger_sel_hi, tx_trigger_sel_lo}));

  // transmit fifo write path, cpu first, dma in any cycle without a cpu push to txdata
  wire cpu_push_req = acc_wr && sel_txdata && lane0;
  wire dma_take     = dma_valid && !cpu_push_req;
  wire push_req     = cpu_push_req || dma_take;
  wire [7:0] push_data = cpu_push_req ? avs_writedata[7:0] : dma_data;
  wire fifo_full    = (count == CW'(DEPTH));
  wire [CW-1:0] low_room = CW'(CW'(DEPTH) - trig);
  wire room         = !fifo_full && (tx_fifo_low_flag || (added < low_room));
  wire push         = push_req && room;
  wire pop          = tx_take && tx_head_valid;
  wire [CW-1:0] next_count = CW'(count + CW'(push) - CW'(pop));

  tx_byte_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH),
    .CW    (CW)
  ) u_tx_fifo (
    .clk        (clk),
    .rst        (rst),
    .push       (push),
    .push_data  (push_data),
    .pop        (pop),
    .head       (tx_head),
    .head_valid (tx_head_valid),
    .count      (count)
  );

  // transmit done
  wire done_set   = tx_char_done && (count == '0) && !push;
  wire done_clear = push && tx_enable_ctl;
  wire next_done  = !tx_enable_ctl ? 1'b1 :
                    done_set ? 1'b1 : (done_clear ? 1'b0 : transmit_done_flag);

  // fifo low
  wire status_wr  = acc_wr && sel_status && lane0;
  wire low_set    = pop && (next_count <= trig);
  wire low_swclr  = status_wr && !avs_writedata[`SF_BIT_LOW] && arm_low && (count > trig);
  wire low_dmaclr = dma_take && push && (next_count > trig);
  wire next_low   = low_set ? 1'b1 : ((low_swclr || low_dmaclr) ? 1'b0 : tx_fifo_low_flag);

  // break detection and zero suppression
  wire break_seen  = rx_char_valid && rx_char.frame_err && prev_frame_err
                     && (rx_char.data == 8'h00);
  wire break_swclr = status_wr && !avs_writedata[`SF_BIT_BREAK] && arm_break;
  wire next_break  = break_seen ? 1'b1 : (break_swclr ? 1'b0 : line_break_flag);
  wire suppress    = break_hold && (rx_char.data == 8'h00);
  wire next_hold   = break_seen ? 1'b1 : (line_sync ? 1'b0 : break_hold);

  // receive fifo read
  wire rx_read    = acc_rd && sel_rxdata;

  // interrupts
  wire irq_bits_t events = {break_seen, low_set, done_set};
  wire irq_bits_t clr    = (acc_wr && sel_iclr && lane0) ? avs_writedata[2:0] : '0;
  wire irq_bits_t next_istat = (irq_status & ~clr) | events;

  // read data
  wire [31:0] status_word = (32'(transmit_done_flag) << `SF_BIT_DONE)
                          | (32'(tx_fifo_low_flag) << `SF_BIT_LOW)
                          | (32'(line_break_flag) << `SF_BIT_BREAK)
                          | (32'(framing_fault_flag) << `SF_BIT_FRAMING)
                          | (32'(parity_fault_flag) << `SF_BIT_PARITY);
  wire [31:0] count_word  = 32'(count) << `SF_COUNT_LSB;
  wire [31:0] next_rdata  = sel_status ? status_word :
                            sel_serctl ? {24'h0, serial_control_reg} :
                            sel_fifoct ? {24'h0, fifo_control_reg} :
                            sel_count  ? count_word :
                            sel_rxdata ? {24'h0, rx_head.data} :
                            sel_istat  ? {29'h0, irq_status} :
                            sel_ien    ? {29'h0, irq_enable} : 32'h0;

  // two-cycle handshake: wait one edge, then accept
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) avs_readdata <= next_rdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_control_reg <= `SF_SERCTL_RESET;
      fifo_control_reg   <= `SF_FIFOCTL_RESET;
      irq_enable         <= '0;
    end else if (acc_wr && lane0) begin
      if (sel_serctl) serial_control_reg <= avs_writedata[7:0];
      if (sel_fifoct) fifo_control_reg <= avs_writedata[7:0];
      if (sel_ien) irq_enable <= avs_writedata[2:0];
    end
  end

  // flags; writes to done and the fault flags have no path here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transmit_done_flag <= 1'(`SF_STATUS_RESET >> `SF_BIT_DONE);
      tx_fifo_low_flag   <= 1'b1;
      line_break_flag    <= 1'b0;
      framing_fault_flag <= 1'b0;
      parity_fault_flag  <= 1'b0;
    end else if (standby) begin
      transmit_done_flag <= 1'b1;
      tx_fifo_low_flag   <= 1'b1;
      line_break_flag    <= 1'b0;
      framing_fault_flag <= 1'b0;
      parity_fault_flag  <= 1'b0;
    end else begin
      transmit_done_flag <= next_done;
      tx_fifo_low_flag   <= next_low;
      line_break_flag    <= next_break;
      if (rx_read) begin
        framing_fault_flag <= rx_head.frame_err;
        parity_fault_flag  <= rx_head.parity_err && !sync_mode;
      end
    end
  end

  // a zero clears only after the flag was seen as one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arm_low   <= 1'b0;
      arm_break <= 1'b0;
    end else if (standby || status_wr) begin
      arm_low   <= 1'b0;
      arm_break <= 1'b0;
    end else if (acc_rd && sel_status) begin
      arm_low   <= tx_fifo_low_flag;
      arm_break <= line_break_flag;
    end
  end

  // bytes added since fifo low dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      added <= '0;
    end else if (next_low) begin
      added <= '0;
    end else if (push) begin
      added <= CW'(added + 1'b1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_meta  <= 1'b1;
      line_sync  <= 1'b1;
      prev_frame_err <= 1'b0;
      break_hold <= 1'b0;
    end else begin
      line_meta  <= rx_line;
      line_sync  <= line_meta;
      break_hold <= standby ? 1'b0 : next_hold;
      if (rx_char_valid) prev_frame_err <= rx_char.frame_err;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_load      <= 1'b0;
      rx_load_char <= '0;
      rx_pop       <= 1'b0;
      dma_ack      <= 1'b0;
    end else begin
      rx_load      <= rx_char_valid && !suppress;
      rx_load_char <= rx_char;
      rx_pop       <= rx_read;
      dma_ack      <= dma_take && room;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_istat;
      irq        <= |(next_istat & irq_enable);
    end
  end

endmodule : serial_fifo_status_flags

// ===== bench/serial_flags_checker.sv
// Purpose: port-level checks of the serial status flag block
// Assumes: one clock, async active-high reset
// Notes:   bound into every instance of the flag block
`include "serial_flags_regs.svh"
module serial_flags_checker
  import serial_flags_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        standby,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        dma_valid,
  input wire logic        dma_ack,
  input wire logic        rx_char_valid,
  input wire rx_char_s    rx_char,
  input wire logic        rx_load,
  input wire rx_char_s    rx_load_char
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_wait_one_low: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("wait not one cycle");
  a_wait_idle_high: assert property (!avs_read && !avs_write && !$past(avs_read)
    && !$past(avs_write) |-> avs_waitrequest) else $error("wait low when idle");
  a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address > 8'h20
    |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!(avs_read && avs_waitrequest)
    |=> $stable(avs_readdata)) else $error("read data moved");
  a_standby_flags: assert property (
    avs_read && avs_waitrequest && avs_address == `SF_OFF_STATUS && standby && $past(standby)
    |=> avs_readdata[6:2] == 5'b11000) else $error("standby flags wrong");
  a_load_nonzero: assert property (
    rx_char_valid && rx_char.data != 8'h00 |=> rx_load && rx_load_char == $past(rx_char))
    else $error("nonzero char not loaded");
  a_load_cause: assert property (rx_load |-> $past(rx_char_valid))
    else $error("load without char");
  a_dma_ack_cause: assert property (dma_ack |-> $past(dma_valid))
    else $error("ack without offer");
endmodule : serial_flags_checker

bind serial_fifo_status_flags serial_flags_checker i_chk (.clk(clk), .rst(rst),
  .standby(standby), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dma_valid(dma_valid),
  .dma_ack(dma_ack), .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_load(rx_load),
  .rx_load_char(rx_load_char));

// ===== bench/line_peer.sv
// Purpose: far side of the line: shifter, receiver and receive fifo
// Assumes: run gates the shifter so the bench can stall it
// Notes:   idle receive lines toggle so no stale value looks valid
module line_peer
  import serial_flags_pkg::*;
(
  input wire logic       clk,
  input wire logic       run,
  input wire logic [7:0] tx_head,
  input wire logic       tx_head_valid,
  output logic           tx_take = 1'b0,
  output logic           tx_char_done = 1'b0,
  output logic           rx_char_valid = 1'b0,
  output rx_char_s       rx_char = '0,
  output logic           rx_line = 1'b1,
  input wire logic       rx_load,
  input wire rx_char_s   rx_load_char,
  output rx_char_s       rx_head = '0,
  input wire logic       rx_pop
);
  logic [7:0] got[$];
  rx_char_s   rxq[$];
  int         busy = 0;
  // one character in flight, seven cycles each, done six cycles after take
  always @(posedge clk) begin
    tx_take <= 1'b0;
    tx_char_done <= busy == 1;
    if (busy > 0) begin
      busy <= busy - 1;
    end else if (run && tx_head_valid === 1'b1) begin
      tx_take <= 1'b1;
      got.push_back(tx_head);
      busy <= 6;
    end
    if (rx_load === 1'b1) rxq.push_back(rx_load_char);
    if (rx_pop === 1'b1 && rxq.size() > 0) void'(rxq.pop_front());
    rx_head <= (rxq.size() > 0) ? rxq[0] : rx_char_s'(~rx_head);
  end
  task automatic send(input logic [7:0] d, input logic f, input logic p);
    @(posedge clk);
    rx_char_valid <= 1'b1;
    rx_char <= '{data: d, frame_err: f, parity_err: p};
    @(posedge clk);
    rx_char_valid <= 1'b0;
    rx_char <= rx_char_s'(~rx_char);
  endtask : send
  task automatic set_line(input logic l);
    @(posedge clk);
    rx_line <= l;
  endtask : set_line
endmodule : line_peer

// ===== bench/tb_serial_fifo_status_flags.sv
// Purpose: register-level test of the serial status flag block
// Assumes: trigger select 1 (four bytes) for the transmit tests
// Notes:   line_peer stands in for shifter, receiver and receive fifo
`include "serial_flags_regs.svh"
module tb_serial_fifo_status_flags
  import serial_flags_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, standby = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic        avs_waitrequest, dma_valid = 1'b0, dma_ack, tx_head_valid, tx_take, irq;
  logic        tx_char_done, rx_char_valid, rx_line, rx_load, rx_pop, run = 1'b0;
  logic [7:0]  avs_address = 8'h00, tx_head;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, v;
  rx_char_s    rx_char, rx_load_char, rx_head;
  int          err_count = 0, cmp_count = 0, cyc = 0, m = 0;
  serial_fifo_status_flags i_dut (.clk(clk), .rst(rst), .standby(standby),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dma_valid(dma_valid), .dma_data(8'h5a),
    .dma_ack(dma_ack), .tx_head(tx_head), .tx_head_valid(tx_head_valid), .tx_take(tx_take),
    .tx_char_done(tx_char_done), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_line(rx_line), .rx_load(rx_load), .rx_load_char(rx_load_char), .rx_head(rx_head),
    .rx_pop(rx_pop), .irq(irq));
  line_peer i_peer (.clk(clk), .run(run), .tx_head(tx_head), .tx_head_valid(tx_head_valid),
    .tx_take(tx_take), .tx_char_done(tx_char_done), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .rx_line(rx_line), .rx_load(rx_load), .rx_load_char(rx_load_char),
    .rx_head(rx_head), .rx_pop(rx_pop));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    v = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), v & mk, e);
  endtask : rchk
  task automatic wait_done();
    do bus(1'b0, `SF_OFF_STATUS, 32'h0); while (v[6] !== 1'b1);
  endtask : wait_done
  task automatic end_of_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk(`SF_OFF_STATUS, 32'hffff_ffff, `SF_STATUS_RESET);
    bus(1'b1, `SF_OFF_SERCTL, 32'h20);
    bus(1'b1, `SF_OFF_FIFOCTL, 32'h10);
    for (int i = 0; i < 17; i++) begin
      if (i == 5) begin
        rchk(`SF_OFF_COUNT, 32'h1f00, 32'h0500);
        bus(1'b1, `SF_OFF_STATUS, 32'hff);
        rchk(`SF_OFF_STATUS, 32'h7c, 32'h20);
        bus(1'b1, `SF_OFF_STATUS, 32'h00);
        rchk(`SF_OFF_STATUS, 32'h7c, 32'h00);
      end
      bus(1'b1, `SF_OFF_TXDATA, 32'h10 + i);
    end
    rchk(`SF_OFF_COUNT, 32'h1f00, 32'h1000);
    run <= 1'b1;
    wait_done();
    run <= 1'b0;
    chk("status", v & 32'h7c, 32'h60);
    chk("sent", i_peer.got.size(), 16);
    for (int i = 0; i < i_peer.got.size(); i++) chk("byte", i_peer.got[i], 32'h10 + i);
    chk("irq", irq, 1'b0);
    dma_valid <= 1'b1;
    repeat (40) begin
      @(posedge clk);
      if (dma_ack === 1'b1) m++;
      if (m >= 5) dma_valid <= 1'b0;
    end
    rchk(`SF_OFF_COUNT, 32'h1f00, m << 8);
    rchk(`SF_OFF_STATUS, 32'h20, 32'h0);
    bus(1'b1, `SF_OFF_IRQ_EN, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq", irq, 1'b1);
    bus(1'b1, `SF_OFF_IRQ_CLR, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq", irq, 1'b0);
    run <= 1'b1;
    wait_done();
    run <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq", irq, 1'b1);
    bus(1'b1, `SF_OFF_IRQ_EN, 32'h0);
    bus(1'b1, `SF_OFF_TXDATA, 32'h77);
    rchk(`SF_OFF_STATUS, 32'h40, 32'h0);
    bus(1'b1, `SF_OFF_SERCTL, 32'h0);
    rchk(`SF_OFF_STATUS, 32'h40, 32'h40);
    i_peer.send(8'h55, 1'b1, 1'b1);
    repeat (2) @(posedge clk);
    rchk(`SF_OFF_RXDATA, 32'hff, 32'h55);
    rchk(`SF_OFF_STATUS, 32'h0c, 32'h0c);
    i_peer.set_line(1'b0);
    repeat (3) i_peer.send(8'h00, 1'b1, 1'b0);
    i_peer.set_line(1'b1);
    repeat (5) @(posedge clk);
    i_peer.send(8'h00, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    chk("rx fifo", i_peer.rxq.size(), 2);
    rchk(`SF_OFF_STATUS, 32'h10, 32'h10);
    rchk(`SF_OFF_RXDATA, 32'hff, 32'h0);
    rchk(`SF_OFF_STATUS, 32'h1c, 32'h18);
    rchk(`SF_OFF_RXDATA, 32'hff, 32'h0);
    rchk(`SF_OFF_STATUS, 32'h1c, 32'h10);
    bus(1'b1, `SF_OFF_STATUS, 32'h0);
    rchk(`SF_OFF_STATUS, 32'h30, 32'h20);
    bus(1'b1, `SF_OFF_SERCTL, 32'h80);
    i_peer.send(8'h33, 1'b1, 1'b1);
    repeat (2) @(posedge clk);
    rchk(`SF_OFF_RXDATA, 32'hff, 32'h33);
    rchk(`SF_OFF_STATUS, 32'h0c, 32'h08);
    bus(1'b1, 8'h40, 32'hff);
    rchk(8'h40, 32'hffff_ffff, 32'h0);
    standby <= 1'b1;
    rchk(`SF_OFF_STATUS, 32'h7c, 32'h60);
    standby <= 1'b0;
    end_of_test();
  end
endmodule : tb_serial_fifo_status_flags
